// ### hw/serial_ram_slave.sv
// Two-wire bus slave in front of a 128 x 8 memory.
// Assumes pull-ups outside; sda_oe_n low means the pin is driven low.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Holds 128 bytes of memory, read and written over the bus.
// - Word pointer advances by one after each data byte moved.
// - Three strap inputs form the low address bits; eight devices share.
// - Answers only when upper address nibble is 1010 and straps match.
// - One bit per clock pulse; data changes while clock high are conditions.
// - Bus idle with both lines high; a start is taken in any state, repeated start included.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop; bus freed.
// - Each byte followed by an acknowledge bit; byte count unlimited.
// - Addressed receiving device pulls data low during acknowledge clock.
// - After no acknowledge on a read, device releases the data line.
// - First byte after start carries the slave address.
// - Bus spikes up to 100 ns are ignored.
// - Reset returns bus logic to idle.
// - Factory strap plus all address straps high selects power saving.
module serial_ram_slave
    import serial_ram_pkg::*;
#(
    parameter int FILT_CYCLES = SPIKE_CYCLES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe_n,
    input  wire logic addr_strap_bit0,
    input  wire logic addr_strap_bit1,
    input  wire logic addr_strap_bit2,
    input  wire logic factory_strap,
    output var  logic power_save,
    output var  logic bus_busy
);
    bus_lines_t          raw;
    bus_lines_t          line;
    bus_lines_t          prev;
    logic [3:0]          strap_meta;
    logic [3:0]          strap_sync;
    slave_state_t        state;
    logic [7:0]          shift;
    logic [2:0]          bit_cnt;
    logic                ack_phase;
    logic                bits_seen;
    logic                drive_low;
    logic                master_nak;
    logic [MEM_AW-1:0]   ptr;
    logic [7:0]          mem [MEM_WORDS];
    logic                scl_rise;
    logic                scl_fall;
    logic                start_cond;
    logic                stop_cond;
    logic [7:0]          rx_byte;
    logic                addr_ok;

    assign raw.scl = scl_in;
    assign raw.sda = sda_in;

    bus_line_filter #(.FILT_CYCLES(FILT_CYCLES)) u_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .raw     (raw),
        .clean   (line)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev <= '1;
        end else begin
            prev <= line;
        end
    end

    assign scl_rise   = line.scl & ~prev.scl;
    assign scl_fall   = ~line.scl & prev.scl;
    assign start_cond = line.scl & prev.scl & prev.sda & ~line.sda;
    assign stop_cond  = line.scl & prev.scl & ~prev.sda & line.sda;
    assign rx_byte    = {shift[6:0], line.sda};

    // Straps come from pins, so synchronise first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_meta <= '0;
            strap_sync <= '0;
        end else begin
            strap_meta <= {factory_strap, addr_strap_bit2,
                           addr_strap_bit1, addr_strap_bit0};
            strap_sync <= strap_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            power_save <= 1'b0;
        end else begin
            power_save <= &strap_sync;
        end
    end

    // Address byte compares after the eighth bit: 1010 plus straps
    assign addr_ok = (shift[7:4] == FIXED_ADDR)
                   && (shift[3:1] == strap_sync[2:0]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_busy <= 1'b0;
        end else if (start_cond) begin
            bus_busy <= 1'b1;
        end else if (stop_cond) begin
            bus_busy <= 1'b0;
        end
    end

    // Protocol engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            shift      <= '0;
            bit_cnt    <= '0;
            ack_phase  <= 1'b0;
            drive_low  <= 1'b0;
            master_nak <= 1'b0;
            ptr        <= '0;
            bits_seen  <= 1'b0;
        end else if (start_cond) begin
            state     <= ST_ADDR;
            bit_cnt   <= '0;
            ack_phase <= 1'b0;
            bits_seen <= 1'b0;
            drive_low <= 1'b0;
        end else if (stop_cond) begin
            state     <= ST_IDLE;
            ack_phase <= 1'b0;
            bits_seen <= 1'b0;
            drive_low <= 1'b0;
        end else if (state != ST_IDLE && state != ST_IGN) begin
            if (scl_rise && !ack_phase) begin
                shift     <= rx_byte;
                bit_cnt   <= bit_cnt + 1'b1;
                bits_seen <= 1'b1;
            end else if (scl_rise && ack_phase && state == ST_RDATA) begin
                master_nak <= line.sda;
            end
            // Clock fall of a start carries no bit, so bits_seen gates it
            if (scl_fall && !ack_phase && bit_cnt == '0 && bits_seen) begin
                // Eight bits done: acknowledge slot follows
                ack_phase <= 1'b1;
                bits_seen <= 1'b0;
                unique case (state)
                    ST_ADDR: begin
                        if (addr_ok) begin
                            drive_low <= 1'b1;
                        end else begin
                            state     <= ST_IGN;
                            drive_low <= 1'b0;
                        end
                    end
                    ST_WPTR: begin
                        ptr       <= shift[MEM_AW-1:0];
                        drive_low <= 1'b1;
                    end
                    ST_WDATA: begin
                        ptr       <= ptr + 1'b1;
                        drive_low <= 1'b1;
                    end
                    ST_RDATA: begin
                        ptr       <= ptr + 1'b1;
                        drive_low <= 1'b0;
                    end
                    default: begin
                        drive_low <= 1'b0;
                    end
                endcase
            end else if (scl_fall && ack_phase) begin
                ack_phase <= 1'b0;
                drive_low <= 1'b0;
                unique case (state)
                    ST_ADDR: begin
                        if (shift[0] == DIR_READ) begin
                            state     <= ST_RDATA;
                            shift     <= mem[ptr];
                            drive_low <= ~mem[ptr][7];
                        end else begin
                            state <= ST_WPTR;
                        end
                    end
                    ST_WPTR: state <= ST_WDATA;
                    ST_WDATA: state <= ST_WDATA;
                    ST_RDATA: begin
                        if (master_nak) begin
                            state <= ST_IGN;
                        end else begin
                            shift     <= mem[ptr];
                            drive_low <= ~mem[ptr][7];
                        end
                    end
                    default: state <= ST_IGN;
                endcase
            end else if (scl_fall && state == ST_RDATA) begin
                // Next bit out, most significant first
                drive_low <= ~shift[7];
            end
        end
    end

    // Storage writes on the data byte's last bit
    always_ff @(posedge clk) begin
        if (!sys_rst && state == ST_WDATA && scl_fall && !ack_phase
            && bit_cnt == '0 && bits_seen && !start_cond && !stop_cond) begin
            mem[ptr] <= shift;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= ~drive_low;
        end
    end
endmodule // serial_ram_slave
`default_nettype wire

// ### hw/serial_ram_pkg.sv
// Package for the two-wire serial memory slave.
// Assumes a 125 MHz system clock; bus lines sampled asynchronously.
package serial_ram_pkg;
    localparam int          CLK_PERIOD_PS   = 8000;
    localparam int          SPIKE_NS        = 100;
    localparam int          SPIKE_CYCLES    =
        (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          MEM_WORDS       = 128;
    localparam int          MEM_AW          = 7;
    localparam logic [3:0]  FIXED_ADDR      = 4'hA;
    localparam logic [2:0]  BIT_LAST        = 3'h7;
    localparam logic        DIR_READ        = 1'b1;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR  = 6'h02,
        ST_WPTR  = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_IGN   = 6'h20
    } slave_state_t;
endpackage

// ### hw/bus_line_filter.sv
// Synchroniser and spike filter for the two bus lines.
// Assumes lines arrive from pins, asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module bus_line_filter
    import serial_ram_pkg::*;
#(
    parameter int FILT_CYCLES = SPIKE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire bus_lines_t raw,
    output var  bus_lines_t clean
);
    localparam int CW = $clog2(FILT_CYCLES + 2);
    bus_lines_t     meta;
    bus_lines_t     sync;
    logic [CW-1:0]  cnt_scl;
    logic [CW-1:0]  cnt_sda;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= '1;
            sync <= '1;
        end else begin
            meta <= raw;
            sync <= meta;
        end
    end

    // Level accepted only after it stays put longer than a spike
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clean   <= '1;
            cnt_scl <= '0;
            cnt_sda <= '0;
        end else begin
            if (sync.scl == clean.scl) begin
                cnt_scl <= '0;
            end else if (cnt_scl == CW'(FILT_CYCLES)) begin
                clean.scl <= sync.scl;
                cnt_scl   <= '0;
            end else begin
                cnt_scl <= cnt_scl + 1'b1;
            end
            if (sync.sda == clean.sda) begin
                cnt_sda <= '0;
            end else if (cnt_sda == CW'(FILT_CYCLES)) begin
                clean.sda <= sync.sda;
                cnt_sda   <= '0;
            end else begin
                cnt_sda <= cnt_sda + 1'b1;
            end
        end
    end
endmodule // bus_line_filter
`default_nettype wire

// ### bench/bus_master_model.sv
// Two-wire bus master model, open drain on data.
// Assumes an 8 ns clk; one phase tick is 64 ns.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic       clk,
    input  wire logic       sda_line,
    output var  logic       scl,
    output var  logic       sda_low,
    output var  logic       got,
    output var  logic [7:0] got_val
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        got = 1'b0;
        got_val = 8'h00;
    end
    task automatic tick();
        repeat (8) @(posedge clk);
    endtask
    // Data set in clock low, sampled mid high
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        tick();
        scl <= 1'b1;
        tick();
        s = sda_line;
        tick();
        scl <= 1'b0;
        tick();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack,
                        input logic is_rd, output logic [7:0] rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(mack, s);
        got_val <= is_rd ? rx : {7'h00, s};
        got <= 1'b1;
        @(posedge clk);
        got <= 1'b0;
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b0;
        tick();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick();
        scl <= 1'b1;
        tick();
        sda_low <= 1'b0;
        tick();
    endtask
    task automatic spike();
        sda_low <= 1'b1;
        @(posedge clk);
        sda_low <= 1'b0;
    endtask
endmodule // bus_master_model
`default_nettype wire

// ### bench/serial_ram_slave_assertions.sv
// Pin checker for the serial memory slave.
// Assumes bind to serial_ram_slave; bit phases of 8 clk.
`timescale 1ns/1ps
`default_nettype none
module serial_ram_slave_assertions #(
    parameter int FILT_CYCLES = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic factory_strap,
    input wire logic power_save,
    input wire logic bus_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic all_hi = factory_strap & addr_strap_bit0 & addr_strap_bit1
        & addr_strap_bit2;
    reset_idle_a: assert property (
        disable iff (1'b0) sys_rst |=> sda_oe_n && !bus_busy && !power_save)
        else $error("outputs not idle in reset");
    save_on_a: assert property (all_hi [*6] |-> power_save)
        else $error("power save missing");
    save_off_a: assert property (!all_hi [*6] |-> !power_save)
        else $error("power save spurious");
    start_busy_a: assert property (scl_in && $fell(sda_in)
        ##1 (scl_in && !sda_in) [*3] |-> ##[1:30] bus_busy)
        else $error("start not seen");
    stop_free_a: assert property (scl_in && $rose(sda_in)
        ##1 (scl_in && sda_in) [*3] |-> ##[1:30] !bus_busy)
        else $error("stop not seen");
    idle_release_a: assert property (!bus_busy |-> sda_oe_n)
        else $error("data driven on idle bus");
    high_stable_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("data changed in clock high");
    ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("low drive too short");
    drive_low_a: assert property (!$past(sys_rst) |-> !sda_out)
        else $error("data driven high");
endmodule // serial_ram_slave_assertions
bind serial_ram_slave serial_ram_slave_assertions #(
    .FILT_CYCLES(FILT_CYCLES)) u_chk (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .scl_in          (scl_in),
    .sda_in          (sda_in),
    .sda_out         (sda_out),
    .sda_oe_n        (sda_oe_n),
    .addr_strap_bit0 (addr_strap_bit0),
    .addr_strap_bit1 (addr_strap_bit1),
    .addr_strap_bit2 (addr_strap_bit2),
    .factory_strap   (factory_strap),
    .power_save      (power_save),
    .bus_busy        (bus_busy)
);
`default_nettype wire

// ### bench/serial_ram_slave_test.sv
// Bench for the serial memory slave with a bus master model.
// Assumes bus_master_model and the bound pin checker.
`timescale 1ns/1ps
`default_nettype none
module serial_ram_slave_test;
    logic        clk, sys_rst, fac, got, oe_n, sda_o, ps, busy, low, scl, sp;
    logic [2:0]  st;
    logic [6:0]  dev;
    logic [7:0]  gv, rd;
    logic [7:0]  d [3];
    logic [8:0]  e;
    logic [8:0]  exp_q [$];
    logic [31:0] rng;
    wire logic   line;
    int          num_errors = 0, check_count = 0, cycles = 0;
    serial_ram_slave #(.FILT_CYCLES(2)) uut (.clk(clk), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(line), .sda_out(sda_o), .sda_oe_n(oe_n),
        .addr_strap_bit0(st[0]), .addr_strap_bit1(st[1]),
        .addr_strap_bit2(st[2]), .factory_strap(fac),
        .power_save(ps), .bus_busy(busy));
    bus_master_model m (.clk(clk), .sda_line(line), .scl(scl),
        .sda_low(low), .got(got), .got_val(gv));
    assign line = low ? 1'b0 : (oe_n ? 1'b1 : sda_o);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk_byte(string n, logic [7:0] x, logic [7:0] v);
        check_count++;
        if (v !== x) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, x, v);
        end
    endtask
    task automatic chk_bit(string n, logic x, logic v);
        chk_byte(n, {7'h00, x}, {7'h00, v});
    endtask
    task automatic wr(logic [7:0] b, logic a);
        exp_q.push_back({1'b0, 7'h00, a});
        m.xfer(b, 1'b1, 1'b0, rd);
    endtask
    task automatic rdb(logic [7:0] b, logic nak);
        exp_q.push_back({1'b1, b});
        m.xfer(8'hFF, nak, 1'b1, rd);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (got === 1'b1) begin
            e = exp_q.pop_front();
            if (e[8]) chk_byte("read", e[7:0], gv);
            else chk_bit("ack", e[0], gv[0]);
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        st = 3'h0;
        fac = 1'b0;
        rng = 32'h5877;
        repeat (12) @(posedge clk);
        chk_bit("oe_n", 1'b1, oe_n);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            {fac, st} <= 4'(k);
            repeat (9) @(posedge clk);
            chk_bit("save", k == 15, ps);
        end
        rng = xs(rng);
        {fac, st} <= {1'b0, rng[2:0]};
        dev = {4'hA, rng[2:0]};
        m.start();
        chk_bit("busy", 1'b1, busy);
        wr({dev, 1'b0}, 1'b0);
        wr(8'h7E, 1'b0);
        for (int j = 0; j < 3; j++) begin
            rng = xs(rng);
            d[j] = rng[7:0];
            wr(d[j], 1'b0);
        end
        m.stop();
        repeat (8) @(posedge clk);
        chk_bit("busy", 1'b0, busy);
        m.start();
        wr({dev, 1'b0}, 1'b0);
        wr(8'h7E, 1'b0);
        m.start();
        wr({dev, 1'b1}, 1'b0);
        for (int j = 0; j < 3; j++) rdb(d[j], j == 2);
        chk_bit("oe_n", 1'b1, oe_n);
        m.stop();
        for (int j = 0; j < 2; j++) begin
            m.start();
            wr(j ? {4'hB, dev[2:0], 1'b0} : {dev ^ 7'h01, 1'b0}, 1'b1);
            wr(8'h00, 1'b1);
            m.stop();
        end
        repeat (8) @(posedge clk);
        sp = 1'b0;
        m.spike();
        // Any one-cycle busy pulse means the spike was taken as start
        repeat (30) begin
            @(posedge clk);
            sp = sp | busy;
        end
        chk_bit("spike", 1'b0, sp);
        chk_bit("busy", 1'b0, busy);
        chk_bit("drained", 1'b1, exp_q.size() == 0);
        finish_test();
    end
endmodule // serial_ram_slave_test
`default_nettype wire
